// *** verilog/adc_clock_mode_config_regs.sv ***
`timescale 1ns/10ps
module adc_clock_mode_config_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register access from the serial command decoder
   input wire logic [3:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   // conversion sequencer
   input wire logic oneShotDone,
   input wire logic [1:0] conversion_sequence_mode,
   // decoded settings
   output adc_cfg_pkg::adc_settings_t settings,
   // analog master clock and clock pin
   output logic analog_master_clock,
   output logic clkPinOut,
   output logic clkPinOe
);

   // stored register images
   logic [7:0] clockBiasMode_r;
   logic [7:0] samplingClock_r;
   // fields of the stored images
   logic [1:0] modeField;
   logic [1:0] clkSrc;
   logic [1:0] biasField;
   logic [1:0] prescale;
   logic [3:0] ratioCode;
   // write selects and the end-of-shot rewrite
   logic wrClockBiasMode;
   logic wrSamplingClock;
   logic shotRewrite;
   logic [1:0] shotMode;
   // decoded values ahead of their flops
   adc_cfg_pkg::op_state_t opState_nxt;
   logic [3:0] divide;
   logic [16:0] ratioValue;
   logic [2:0] divTerminal;
   logic pinDrive;
   // flops behind the settings bundle
   logic internalClk_r;
   logic externalClk_r;
   logic [1:0] biasCode_r;
   adc_cfg_pkg::op_state_t opState_r;
   logic [3:0] prescaleDiv_r;
   logic [16:0] ratio_r;
   logic specialCond_r;
   // divider state
   logic [2:0] divCount_r;
   logic masterTick_nxt;

   // field taps
   assign modeField = clockBiasMode_r[adc_cfg_pkg::MODE_LSB +: 2];
   assign clkSrc = clockBiasMode_r[adc_cfg_pkg::CLKSRC_LSB +: 2];
   assign biasField = clockBiasMode_r[adc_cfg_pkg::BIAS_LSB +: 2];
   assign prescale = samplingClock_r[adc_cfg_pkg::PRESCALE_LSB +: 2];
   assign ratioCode = samplingClock_r[adc_cfg_pkg::RATIO_LSB +: 4];

   // address decode for the two writable images
   assign wrClockBiasMode = regWrEn &&
      (regAddr == adc_cfg_pkg::ADDR_CLOCK_BIAS_MODE); // R10
   assign wrSamplingClock = regWrEn &&
      (regAddr == adc_cfg_pkg::ADDR_SAMPLING_CLOCK);

   // a one-shot end only rewrites outside continuous sequencing
   assign shotRewrite = oneShotDone &&
      (conversion_sequence_mode != adc_cfg_pkg::SEQ_CONTINUOUS); // R11
   assign shotMode =
      (conversion_sequence_mode == adc_cfg_pkg::SEQ_ONESHOT_STANDBY) ?
      adc_cfg_pkg::MODE_STANDBY : adc_cfg_pkg::MODE_SHUTDOWN; // R11

   // first register: host writes, then the end-of-shot mode rewrite;
   // a host write in the same cycle wins, it is the newer intent
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clockBiasMode_r <= adc_cfg_pkg::RESET_CLOCK_BIAS_MODE;
      end else if (wrClockBiasMode) begin
         clockBiasMode_r <= regWrData; // R10
      end else if (shotRewrite) begin
         clockBiasMode_r[adc_cfg_pkg::MODE_LSB +: 2] <= shotMode; // R11
      end
   end

   // second register; the low pair is stored as written
   always_ff @(posedge core_clk) begin
      if (rst) begin
         samplingClock_r <= adc_cfg_pkg::RESET_SAMPLING_CLOCK;
      end else if (wrSamplingClock) begin
         samplingClock_r <= regWrData; // R8
      end
   end

   // read path, unmapped addresses read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regAddr == adc_cfg_pkg::ADDR_CLOCK_BIAS_MODE) begin
         regRdData <= clockBiasMode_r;
      end else if (regAddr == adc_cfg_pkg::ADDR_SAMPLING_CLOCK) begin
         regRdData <= samplingClock_r;
      end else begin
         regRdData <= 8'h00;
      end
   end

   // operating-mode decode; both shutdown codes fold together
   always_comb begin
      case (modeField) // R5
         adc_cfg_pkg::MODE_CONVERT: opState_nxt = adc_cfg_pkg::OP_CONVERT;
         adc_cfg_pkg::MODE_STANDBY: opState_nxt = adc_cfg_pkg::OP_STANDBY;
         default: opState_nxt = adc_cfg_pkg::OP_SHUTDOWN;
      endcase
   end

   // prescaler decode; codes 01 and 10 are assumed to halve and quarter
   always_comb begin
      case (prescale) // R9
         2'h3: divide = 4'h8;
         2'h2: divide = 4'h4;
         2'h1: divide = 4'h2;
         default: divide = 4'h1;
      endcase
   end

   // last count value of the divider, cut to the counter's width
   assign divTerminal = 3'(divide - 4'h1);

   // oversampling decode; the two lowest and two highest codes share
   always_comb begin
      case (ratioCode) // R7
         4'h0: ratioValue = 17'h0_0040;
         4'h1: ratioValue = 17'h0_0040;
         4'h2: ratioValue = 17'h0_0080;
         4'h3: ratioValue = 17'h0_0100;
         4'h4: ratioValue = 17'h0_0200;
         4'h5: ratioValue = 17'h0_0400;
         4'h6: ratioValue = 17'h0_0800;
         4'h7: ratioValue = 17'h0_1000;
         4'h8: ratioValue = 17'h0_2000;
         4'h9: ratioValue = 17'h0_4000;
         4'ha: ratioValue = 17'h0_5000;
         4'hb: ratioValue = 17'h0_6000;
         4'hc: ratioValue = 17'h0_a000;
         4'hd: ratioValue = 17'h0_c000;
         default: ratioValue = 17'h1_4000;
      endcase
   end

   // clock-source view, one cycle behind the register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         internalClk_r <= 1'b0;
         externalClk_r <= 1'b0;
      end else begin
         internalClk_r <= clkSrc[1]; // R1 R2
         externalClk_r <= ~clkSrc[1]; // R3
      end
   end

   // bias-current code passed on unchanged to the analog side
   always_ff @(posedge core_clk) begin
      if (rst) begin
         biasCode_r <= 2'h0;
      end else begin
         biasCode_r <= biasField; // R4
      end
   end

   // operating state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         opState_r <= adc_cfg_pkg::OP_SHUTDOWN;
      end else begin
         opState_r <= opState_nxt; // R5
      end
   end

   // sampling settings: divider and oversampling ratio
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prescaleDiv_r <= 4'h0;
         ratio_r <= 17'h0_0000;
      end else begin
         prescaleDiv_r <= divide; // R9
         ratio_r <= ratioValue; // R7
      end
   end

   // all-zero first register is flagged on its own
   always_ff @(posedge core_clk) begin
      if (rst) begin
         specialCond_r <= 1'b0;
      end else begin
         specialCond_r <= (clockBiasMode_r == 8'h00); // R6
      end
   end

   // the bundle is wiring only, each member leaves its own flop
   assign settings = '{
      internalClk: internalClk_r,
      externalClk: externalClk_r,
      biasCode: biasCode_r,
      opState: opState_r,
      prescaleDiv: prescaleDiv_r,
      oversamplingRatio: ratio_r,
      specialCond: specialCond_r
   };

   // divider: one-cycle tick every divide cycles of the master clock;
   // a tick rather than a derived clock keeps a single clock domain
   assign masterTick_nxt = (divCount_r == divTerminal);

   // a divider change mid-count may let the count wrap first, so the
   // first tick at the new rate can come up to seven cycles late
   always_ff @(posedge core_clk) begin
      if (rst) begin
         divCount_r <= 3'h0;
      end else begin
         divCount_r <= masterTick_nxt ? 3'h0 : divCount_r + 3'h1; // R9
      end
   end

   // tick flop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         analog_master_clock <= 1'b0;
      end else begin
         analog_master_clock <= masterTick_nxt; // R9
      end
   end

   // clock pin driven only in internal-with-output mode
   assign pinDrive = (clkSrc == adc_cfg_pkg::CLKSRC_INT_OUT); // R1 R2

   // pin enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clkPinOe <= 1'b0;
      end else begin
         clkPinOe <= pinDrive; // R1 R2
      end
   end

   // pin level follows the tick only while the pin is driven
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clkPinOut <= 1'b0;
      end else begin
         clkPinOut <= pinDrive && masterTick_nxt; // R1
      end
   end

endmodule : adc_clock_mode_config_regs

// *** verilog/adc_cfg_pkg.sv ***
// Notes on behaviour
// R1: Clock-source code 11 selects the internal oscillator and drives the analog master clock out on the clock pin.
// R2: Clock-source code 10 selects the internal oscillator and leaves the clock pin undriven.
// R3: Clock-source codes 01 and 00 select the external digital clock, and 00 is the reset value.
// R4: The bias-current code sources on the positive input and sinks on the negative one: 11 is 15 uA, 10 is 3.7 uA, 01 is 0.9 uA, 00 is off.
// R5: The operating-mode code gives conversion for 11, standby for 10 and shutdown for 01 or 00, and 00 is the reset value.
// R6: The first register reading upper bits 00 with every other bit 0 is flagged as a distinct special condition.
// R7: Bits 5 to 2 of the second register pick an oversampling ratio from a fixed table from 64 to 81920, and 256 after reset.
// R8: The host always writes 00 into the two low reserved bits of the second register.
// R9: The prescaler code divides the master clock into the analog master clock: 11 by eight, 00 by one.
// R10: The first register, holding mode, clock source and bias current, sits at address 0x1 and is 8 bits wide.
// R11: When a one-shot conversion ends, the mode field is rewritten to standby or shutdown as the sequence mode says; a same-cycle host write wins instead.
package adc_cfg_pkg;

   // register addresses
   localparam logic [3:0] ADDR_CLOCK_BIAS_MODE = 4'h1;
   localparam logic [3:0] ADDR_SAMPLING_CLOCK = 4'h2;

   // values after reset
   localparam logic [7:0] RESET_CLOCK_BIAS_MODE = 8'hc0;
   localparam logic [7:0] RESET_SAMPLING_CLOCK = 8'h0c;

   // field positions
   localparam int MODE_LSB = 0;
   localparam int BIAS_LSB = 2;
   localparam int CLKSRC_LSB = 4;
   localparam int UPPER_LSB = 6;
   localparam int RATIO_LSB = 2;
   localparam int PRESCALE_LSB = 6;

   // clock-source codes
   localparam logic [1:0] CLKSRC_INT_OUT = 2'h3;
   localparam logic [1:0] CLKSRC_INT = 2'h2;

   // operating-mode codes
   localparam logic [1:0] MODE_CONVERT = 2'h3;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;

   // sequence-mode codes
   localparam logic [1:0] SEQ_CONTINUOUS = 2'h3;
   localparam logic [1:0] SEQ_ONESHOT_STANDBY = 2'h2;

   typedef enum logic [1:0] {
      OP_SHUTDOWN,
      OP_STANDBY,
      OP_CONVERT
   } op_state_t;

   // decoded settings handed to the analog side
   typedef struct packed {
      logic internalClk;
      logic externalClk;
      logic [1:0] biasCode;
      op_state_t opState;
      logic [3:0] prescaleDiv;
      logic [16:0] oversamplingRatio;
      logic specialCond;
   } adc_settings_t;

endpackage : adc_cfg_pkg

// *** sim/cfg_regs_monitor.sv ***
`timescale 1ns/10ps
module cfg_regs_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register side and sequencer
   input wire logic [3:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic oneShotDone,
   input wire logic [1:0] conversion_sequence_mode,
   // decoded outputs
   input wire adc_cfg_pkg::adc_settings_t settings,
   input wire logic analog_master_clock,
   input wire logic clkPinOut,
   input wire logic clkPinOe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // write strobes per register
   wire w1 = regWrEn && regAddr == 4'h1;
   wire w2 = regWrEn && regAddr == 4'h2;
   // write data delayed to line up with the decoded outputs
   logic [7:0] d1_r;
   logic [7:0] d2_r;
   always_ff @(posedge core_clk) begin
      d1_r <= regWrData;
      d2_r <= d1_r;
   end
   a_pin_out: assert property (
      w1 |-> ##2 clkPinOe == (d2_r[5:4] == 2'h3)) else $error("pin enable");
   a_ext_clk: assert property (
      w1 |-> ##2 settings.externalClk == !d2_r[5]) else $error("ext clock");
   a_bias_code: assert property (
      w1 |-> ##2 settings.biasCode == d2_r[3:2]) else $error("bias code");
   a_mode_decode: assert property (
      w1 |-> ##2 settings.opState == (d2_r[1:0] == 2'h3 ?
      adc_cfg_pkg::OP_CONVERT : d2_r[1] ? adc_cfg_pkg::OP_STANDBY :
      adc_cfg_pkg::OP_SHUTDOWN)) else $error("mode decode");
   a_special_flag: assert property (
      w1 |-> ##2 settings.specialCond == (d2_r == 8'h00)) else $error("flag");
   a_prescale_div: assert property (
      w2 |-> ##2 settings.prescaleDiv == 4'h1 << d2_r[7:6])
      else $error("div");
   a_tick_gap: assert property (
      analog_master_clock |=> !analog_master_clock ||
      settings.prescaleDiv == 4'h1) else $error("tick gap");
   a_pin_copy: assert property (
      clkPinOut == (clkPinOe && analog_master_clock))
      else $error("pin copy");
   a_read_back: assert property (
      w1 ##1 regAddr == 4'h1 |=> regRdData == d2_r) else $error("read back");
   a_shot_standby: assert property (
      oneShotDone && conversion_sequence_mode == 2'h2 && !w1 |-> ##2
      settings.opState == adc_cfg_pkg::OP_STANDBY) else $error("one-shot");
endmodule : cfg_regs_monitor

// *** sim/host_model.sv ***
`timescale 1ns/10ps
module host_model (
   // clock
   input wire logic core_clk,
   // register write port
   output logic [3:0] regAddr,
   output logic regWrEn,
   output logic [7:0] regWrData
);
   // idle on the first register so reads show it
   initial begin
      regAddr = 4'h1;
      regWrEn = 1'b0;
      regWrData = 8'h00;
   end
   // one byte, then data scrambled so a stale value never looks valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrEn <= 1'b1;
      regWrData <= (a == 4'h2) ? {d[7:2], 2'h0} : d;
      @(posedge core_clk);
      regWrEn <= 1'b0;
      regWrData <= ~regWrData;
   endtask : wr
endmodule : host_model

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic oneShotDone = 1'b0;
   logic [1:0] seqMode = 2'h0;
   logic [3:0] regAddr;
   logic regWrEn;
   logic [7:0] regWrData;
   logic [7:0] regRdData;
   adc_cfg_pkg::adc_settings_t settings;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // first register's fields gathered for one compare
   wire [16:0] cfgView = {10'h000, settings.internalClk, settings.externalClk,
      settings.biasCode, settings.opState, settings.specialCond};
   // address, data, read-back, decoded view or ratio
   logic [36:0] rows [9] = '{
      {4'h1, 8'hc3, 8'hc3, 17'h0_0024}, {4'h1, 8'hf9, 8'hf9, 17'h0_0050},
      {4'h1, 8'h26, 8'h26, 17'h0_004a}, {4'h1, 8'h00, 8'h00, 17'h0_0021},
      {4'h2, 8'h44, 8'h44, 17'h0_0040}, {4'h2, 8'h9c, 8'h9c, 17'h0_1000},
      {4'h2, 8'h2a, 8'h28, 17'h0_5000}, {4'h2, 8'hfc, 8'hfc, 17'h1_4000},
      {4'h5, 8'haa, 8'h00, 17'h0_0021}};
   logic [7:0] shotExp [4] = '{8'hc0, 8'hc0, 8'hc2, 8'hc3};
   always #4 core_clk = ~core_clk;
   host_model i_host_model (.core_clk(core_clk), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData));
   adc_clock_mode_config_regs i_adc_clock_mode_config_regs (
      .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdData(regRdData),
      .oneShotDone(oneShotDone), .conversion_sequence_mode(seqMode),
      .settings(settings), .analog_master_clock(), .clkPinOut(),
      .clkPinOe());
   task chk(input string n, input logic [16:0] e, input logic [16:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle
   // a hang costs a mismatch
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         rst <= 1'b1;
         repeat (8) @(posedge core_clk);
         rst <= 1'b0;
         settle(2);
         chk("reset value", 17'h0_00c0, {9'h000, regRdData});
         chk("reset view", 17'h0_0020, cfgView);
         if (k == 0) begin
            foreach (rows[i]) begin
               i_host_model.wr(rows[i][36:33], rows[i][32:25]);
               settle(2);
               chk("read", {9'h000, rows[i][24:17]},
                  {9'h000, regRdData});
               chk("decode", rows[i][16:0], rows[i][36:33] == 4'h2 ?
                  settings.oversamplingRatio : cfgView);
            end
            // sequence modes: continuous ignores the end pulse
            for (int m = 0; m < 4; m++) begin
               i_host_model.wr(4'h1, 8'hc3);
               oneShotDone <= 1'b1;
               seqMode <= m[1:0];
               @(posedge core_clk);
               oneShotDone <= 1'b0;
               settle(2);
               chk("one-shot", {9'h000, shotExp[m]},
                  {9'h000, regRdData});
            end
         end
      end
      end_sim();
   end
endmodule : tb_top
bind adc_clock_mode_config_regs cfg_regs_monitor i_cfg_regs_monitor (
   .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
   .regWrData(regWrData), .regRdData(regRdData), .oneShotDone(oneShotDone),
   .conversion_sequence_mode(conversion_sequence_mode), .settings(settings),
   .analog_master_clock(analog_master_clock), .clkPinOut(clkPinOut),
   .clkPinOe(clkPinOe));
